// ### bench/target_model.sv
// Behavioural model of the internal units and downstream buses answering routed cycles
`timescale 1ns/1ps
module target_model (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic tgt_valid,
  input wire fixed_io_pkg::io_cmd_s tgt_cmd,
  input wire logic [3:0] delay,
  output logic tgt_ack,
  output logic [7:0] tgt_rdata
);
  // ------------------------------------------------------------
  // Answer after a programmable wait
  // ------------------------------------------------------------
  logic [3:0] cnt;

  // Data toggles outside the ack cycle so a stale capture cannot pass
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 4'h0;
      tgt_ack <= 1'b0;
      tgt_rdata <= 8'h00;
    end else if (!tgt_valid || tgt_ack) begin
      cnt <= 4'h0;
      tgt_ack <= 1'b0;
      tgt_rdata <= ~tgt_rdata;
    end else if (cnt == delay) begin
      tgt_ack <= 1'b1;
      tgt_rdata <= tgt_cmd.addr[7:0] ^ 8'h5a;
    end else begin
      cnt <= cnt + 4'h1;
      tgt_rdata <= ~tgt_rdata;
    end
  end
endmodule : target_model

// ### bench/tb_top.sv
// Self-checking bench for the fixed I/O address decoder
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic host_valid = 1'b0;
  logic host_ready;
  fixed_io_pkg::io_cmd_s host_cmd = '0;
  logic host_done;
  fixed_io_pkg::io_rsp_s host_rsp;
  logic post_to_pcie = 1'b0;
  logic tgt_valid;
  fixed_io_pkg::target_e tgt_sel;
  fixed_io_pkg::io_cmd_s tgt_cmd;
  logic tgt_ack;
  logic [7:0] tgt_rdata;
  logic [3:0] delay = 4'h0;
  int num_errors = 0;
  int samples_checked = 0;

  always #20 ref_clk = ~ref_clk;

  fixed_io_address_decoder u_dut (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .host_valid(host_valid),
    .host_ready(host_ready),
    .host_cmd(host_cmd),
    .host_done(host_done),
    .host_rsp(host_rsp),
    .post_to_pcie(post_to_pcie),
    .tgt_valid(tgt_valid),
    .tgt_sel(tgt_sel),
    .tgt_cmd(tgt_cmd),
    .tgt_ack(tgt_ack),
    .tgt_rdata(tgt_rdata)
  );

  target_model u_target (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .tgt_valid(tgt_valid),
    .tgt_cmd(tgt_cmd),
    .delay(delay),
    .tgt_ack(tgt_ack),
    .tgt_rdata(tgt_rdata)
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One host cycle judged on target, forwarded command, answer and latency
  task automatic io(input logic wr, input logic [15:0] a, input fixed_io_pkg::target_e t,
                    input logic rsvd);
    fixed_io_pkg::target_e sel;
    fixed_io_pkg::io_cmd_s cmd;
    logic miss;
    int n;
    sel = fixed_io_pkg::TGT_NONE;
    cmd = '0;
    miss = (t == fixed_io_pkg::TGT_NONE);
    host_cmd = {wr, a, ~a[7:0]};
    host_valid = 1'b1;
    // Ready is judged at the falling edge, where it has settled
    for (n = 0; n < 20 && host_ready !== 1'b1; n++) begin
      @(negedge ref_clk);
    end
    @(negedge ref_clk);
    host_valid = 1'b0;
    for (n = 1; n < 30 && host_done !== 1'b1; n++) begin
      if (tgt_valid === 1'b1) begin
        sel = tgt_sel;
        cmd = tgt_cmd;
      end
      @(negedge ref_clk);
    end
    chk(sel, t);
    if (!miss) chk(cmd, {wr, a, ~a[7:0]});
    chk(host_rsp, {!miss || rsvd, rsvd, (wr || miss) ? 8'hff : a[7:0] ^ 8'h5a});
    chk(25'(n), 25'(miss ? 1 : 3 + delay));
    // One idle cycle keeps the valid strobe from being lowered and raised in one step
    @(negedge ref_clk);
  endtask : io

  task automatic rw(input logic [15:0] a, input fixed_io_pkg::target_e t);
    io(1'b0, a, t, 1'b0);
    io(1'b1, a, t, 1'b0);
  endtask : rw

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_units();
    rw(16'h0020, fixed_io_pkg::TGT_PIC_MAIN);
    rw(16'h003d, fixed_io_pkg::TGT_PIC_MAIN);
    rw(16'h002e, fixed_io_pkg::TGT_LPC);
    rw(16'h004f, fixed_io_pkg::TGT_LPC);
    rw(16'h0040, fixed_io_pkg::TGT_TIMER);
    rw(16'h0053, fixed_io_pkg::TGT_TIMER);
    rw(16'h0060, fixed_io_pkg::TGT_LPC);
    rw(16'h0066, fixed_io_pkg::TGT_LPC);
    rw(16'h0061, fixed_io_pkg::TGT_NMI);
    rw(16'h0067, fixed_io_pkg::TGT_NMI);
    rw(16'h0071, fixed_io_pkg::TGT_RTC);
    rw(16'h0077, fixed_io_pkg::TGT_RTC);
    rw(16'h009e, fixed_io_pkg::TGT_LPC);
    rw(16'h0092, fixed_io_pkg::TGT_RESET);
    rw(16'h00a0, fixed_io_pkg::TGT_PIC_SUB);
    rw(16'h00bd, fixed_io_pkg::TGT_PIC_SUB);
    rw(16'h00b3, fixed_io_pkg::TGT_PWR);
    rw(16'h0200, fixed_io_pkg::TGT_LPC);
    rw(16'h020f, fixed_io_pkg::TGT_LPC);
    rw(16'h04d1, fixed_io_pkg::TGT_PIC_MAIN);
    rw(16'h0cf9, fixed_io_pkg::TGT_RESET);
    $display("test_units done");
  endtask : test_units

  task automatic test_post();
    for (int p = 0; p < 2; p++) begin
      post_to_pcie = p[0];
      rw(16'h0080, p[0] ? fixed_io_pkg::TGT_PCIE : fixed_io_pkg::TGT_LPC);
      io(1'b1, 16'h0084, p[0] ? fixed_io_pkg::TGT_PCIE : fixed_io_pkg::TGT_LPC, 1'b0);
      io(1'b0, 16'h008e, fixed_io_pkg::TGT_NONE, 1'b1);
      rw(16'h0090, fixed_io_pkg::TGT_LPC);
    end
    post_to_pcie = 1'b0;
    $display("test_post done");
  endtask : test_post

  task automatic test_port70();
    io(1'b0, 16'h0070, fixed_io_pkg::TGT_RTC, 1'b0);
    io(1'b1, 16'h0070, fixed_io_pkg::TGT_RTC_NMI, 1'b0);
    $display("test_port70 done");
  endtask : test_port70

  task automatic test_unclaimed();
    logic [15:0] addrs [14] = '{16'h0022, 16'h0041, 16'h0068, 16'h0081, 16'h0093,
                                16'h0099, 16'h0210, 16'h04d2, 16'h0cf8, 16'h1cf9,
                                16'h0054, 16'h0089, 16'h008b, 16'h00a2};
    foreach (addrs[i]) rw(addrs[i], fixed_io_pkg::TGT_NONE);
    $display("test_unclaimed done");
  endtask : test_unclaimed

  // A slow unit must hold the host off until it answers
  task automatic test_slow();
    delay = 4'h3;
    rw(16'h0061, fixed_io_pkg::TGT_NMI);
    rw(16'h00b2, fixed_io_pkg::TGT_PWR);
    delay = 4'h0;
    $display("test_slow done");
  endtask : test_slow

  // Reset cut into a waiting cycle must free both sides at once
  task automatic test_reset();
    delay = 4'h3;
    host_cmd = {1'b0, 16'h0061, 8'h9e};
    host_valid = 1'b1;
    @(negedge ref_clk);
    host_valid = 1'b0;
    chk({tgt_valid, tgt_sel}, {1'b1, fixed_io_pkg::TGT_NMI});
    rst_b = 1'b0;
    @(negedge ref_clk);
    chk({host_ready, host_done, tgt_valid, tgt_sel, host_rsp},
        {3'h4, fixed_io_pkg::TGT_NONE, 10'h000});
    rst_b = 1'b1;
    io(1'b0, 16'h0063, fixed_io_pkg::TGT_NMI, 1'b0);
    delay = 4'h0;
    $display("test_reset done");
  endtask : test_reset

  initial begin
    repeat (8) @(negedge ref_clk);
    rst_b = 1'b1;
    test_units();
    test_post();
    test_port70();
    test_unclaimed();
    test_slow();
    test_reset();
    summarize();
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    summarize();
  end
endmodule : tb_top

// ### hdl/fixed_io_address_decoder.sv
// Fixed legacy I/O port decoder steering host cycles to internal units or downstream
`timescale 1ns/1ps

module fixed_io_address_decoder (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic host_valid,
  output logic host_ready,
  input wire fixed_io_pkg::io_cmd_s host_cmd,
  output logic host_done,
  output fixed_io_pkg::io_rsp_s host_rsp,
  input wire logic post_to_pcie,
  output logic tgt_valid,
  output fixed_io_pkg::target_e tgt_sel,
  output fixed_io_pkg::io_cmd_s tgt_cmd,
  input wire logic tgt_ack,
  input wire logic [7:0] tgt_rdata
);

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // Low nibbles 4-6, 8 and C-E: the sparse pattern shared by the 80h and 90h blocks
  function automatic logic sparse_low(input logic [3:0] n);
    case (n[3:2])
      2'h1: sparse_low = (n[1:0] != 2'h3);
      2'h2: sparse_low = (n[1:0] == 2'h0);
      2'h3: sparse_low = (n[1:0] != 2'h3);
      default: sparse_low = 1'b0;
    endcase
  endfunction : sparse_low

  function automatic fixed_io_pkg::target_e decode(input logic [15:0] a, input logic wr,
                                                   input logic to_pcie);
    fixed_io_pkg::target_e post;
    logic sparse;
    // Destination select is taken with the command, so a late change cannot split a cycle
    post = to_pcie ? fixed_io_pkg::TGT_PCIE : fixed_io_pkg::TGT_LPC;
    sparse = sparse_low(a[3:0]);
    decode = fixed_io_pkg::TGT_NONE;
    if ((a & fixed_io_pkg::PIC_MASK) == fixed_io_pkg::PIC_MAIN_MATCH) begin
      decode = fixed_io_pkg::TGT_PIC_MAIN;
    end else if (a[15:1] == fixed_io_pkg::CFG_IDX_A[15:1] ||
                 a[15:1] == fixed_io_pkg::CFG_IDX_B[15:1]) begin
      decode = fixed_io_pkg::TGT_LPC;
    end else if ((a & fixed_io_pkg::TIMER_MASK) == fixed_io_pkg::TIMER_MATCH &&
                 a[1:0] != 2'h1) begin
      decode = fixed_io_pkg::TGT_TIMER;
    end else if ((a & fixed_io_pkg::BLK8_MASK) == fixed_io_pkg::KBC_MATCH) begin
      decode = a[0] ? fixed_io_pkg::TGT_NMI : fixed_io_pkg::TGT_LPC;
    end else if ((a & fixed_io_pkg::BLK8_MASK) == fixed_io_pkg::RTC_MATCH) begin
      if (a[2:0] == 3'h0 && wr) begin
        decode = fixed_io_pkg::TGT_RTC_NMI;
      end else begin
        decode = fixed_io_pkg::TGT_RTC;
      end
    end else if (a == fixed_io_pkg::POST_PORT) begin
      decode = post;
    end else if ((a & fixed_io_pkg::BLK16_MASK) == fixed_io_pkg::POST_PORT && sparse) begin
      decode = wr ? post : fixed_io_pkg::TGT_RSVD;
    end else if (a == fixed_io_pkg::FAST_RESET || a == fixed_io_pkg::RESET_CTL) begin
      decode = fixed_io_pkg::TGT_RESET;
    end else if ((a & fixed_io_pkg::BLK16_MASK) == fixed_io_pkg::POST_ALIAS_MATCH &&
                 (sparse || a[3:0] == 4'h0)) begin
      // Aliases always reach LPC/eSPI, whatever port 80h selects
      decode = fixed_io_pkg::TGT_LPC;
    end else if (a[15:1] == fixed_io_pkg::PWR_BASE[15:1]) begin
      decode = fixed_io_pkg::TGT_PWR;
    end else if ((a & fixed_io_pkg::PIC_MASK) == fixed_io_pkg::PIC_SUB_MATCH) begin
      decode = fixed_io_pkg::TGT_PIC_SUB;
    end else if ((a & fixed_io_pkg::BLK16_MASK) == fixed_io_pkg::GAME_MATCH) begin
      decode = fixed_io_pkg::TGT_LPC;
    end else if (in_range(a, fixed_io_pkg::EDGE_LEVEL_BASE,
                          fixed_io_pkg::EDGE_LEVEL_BASE + 16'h0001)) begin
      decode = fixed_io_pkg::TGT_PIC_MAIN;
    end
  endfunction : decode

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    fixed_io_pkg::state_e st;
    fixed_io_pkg::target_e sel;
    fixed_io_pkg::io_cmd_s cmd;
    fixed_io_pkg::io_rsp_s rsp;
  } dec_state_s;

  dec_state_s cur;
  dec_state_s next_cur;
  fixed_io_pkg::target_e hit;

  // Decoded every cycle; only the result of the take cycle is kept
  assign hit = decode(host_cmd.addr, host_cmd.wr, post_to_pcie);

  always_comb begin
    next_cur = cur;
    case (cur.st)
      fixed_io_pkg::ST_IDLE: begin
        if (host_valid) begin
          next_cur.cmd = host_cmd;
          next_cur.sel = hit;
          next_cur.rsp.claim = (hit != fixed_io_pkg::TGT_NONE);
          next_cur.rsp.rsvd = (hit == fixed_io_pkg::TGT_RSVD);
          next_cur.rsp.rdata = fixed_io_pkg::FLOAT_DATA;
          // Reserved and unclaimed cycles never reach a target
          if (hit == fixed_io_pkg::TGT_NONE || hit == fixed_io_pkg::TGT_RSVD) begin
            next_cur.st = fixed_io_pkg::ST_RESP;
          end else begin
            next_cur.st = fixed_io_pkg::ST_ISSUE;
          end
        end
      end
      fixed_io_pkg::ST_ISSUE: begin
        // Read data is taken only with the acknowledge; the bus carries junk before it
        if (tgt_ack) begin
          if (!cur.cmd.wr) begin
            next_cur.rsp.rdata = tgt_rdata;
          end
          next_cur.st = fixed_io_pkg::ST_RESP;
        end
      end
      fixed_io_pkg::ST_RESP: begin
        next_cur.st = fixed_io_pkg::ST_IDLE;
      end
      default: begin
        next_cur.st = fixed_io_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur.st <= fixed_io_pkg::ST_IDLE;
      cur.sel <= fixed_io_pkg::TGT_NONE;
      cur.cmd <= '0;
      cur.rsp <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Handshake outputs decode the state register; data outputs come straight from flops
  assign host_ready = (cur.st == fixed_io_pkg::ST_IDLE);
  assign host_done = (cur.st == fixed_io_pkg::ST_RESP);
  assign host_rsp = cur.rsp;
  assign tgt_valid = (cur.st == fixed_io_pkg::ST_ISSUE);
  assign tgt_sel = cur.sel;
  assign tgt_cmd = cur.cmd;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Checks watch the handshake as the host sees it
  logic take;
  logic [15:0] ta;
  assign take = host_valid && host_ready;
  assign ta = host_cmd.addr;

  sequence taken_at(logic [15:0] lo, logic [15:0] hi);
    take && ta >= lo && ta <= hi;
  endsequence

  sequence routed(fixed_io_pkg::target_e t);
    tgt_valid && tgt_sel == t;
  endsequence

  pic_main_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && ta >= 16'h0020 && ta <= 16'h003d && ta[1] == 1'b0
    |=> routed(fixed_io_pkg::TGT_PIC_MAIN))
    else $error("primary interrupt port misrouted");
  cfg_index_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    taken_at(16'h002e, 16'h002f) or taken_at(16'h004e, 16'h004f)
    |=> routed(fixed_io_pkg::TGT_LPC))
    else $error("config index port not forwarded");
  timer_port_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && (ta == 16'h0040 || ta == 16'h0042 || ta == 16'h0043 ||
             ta == 16'h0050 || ta == 16'h0052 || ta == 16'h0053)
    |=> routed(fixed_io_pkg::TGT_TIMER))
    else $error("timer port misrouted");
  kbc_fwd_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && (ta == 16'h0060 || ta == 16'h0062 || ta == 16'h0064 || ta == 16'h0066)
    |=> routed(fixed_io_pkg::TGT_LPC))
    else $error("controller port not forwarded");
  nmi_port_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && (ta == 16'h0061 || ta == 16'h0063 || ta == 16'h0065 || ta == 16'h0067)
    |=> routed(fixed_io_pkg::TGT_NMI))
    else $error("NMI port misrouted");
  rtc_index_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && ta == 16'h0070
    |=> tgt_valid && (tgt_cmd.wr ? tgt_sel == fixed_io_pkg::TGT_RTC_NMI
                                 : tgt_sel == fixed_io_pkg::TGT_RTC))
    else $error("port 70h split wrong");
  rtc_data_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    taken_at(16'h0071, 16'h0077) |=> routed(fixed_io_pkg::TGT_RTC))
    else $error("clock port misrouted");
  post_dest_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && ta == 16'h0080 && post_to_pcie |=> routed(fixed_io_pkg::TGT_PCIE))
    else $error("port 80h destination ignored");
  post_rsvd_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && !host_cmd.wr && (ta == 16'h0084 || ta == 16'h0088 || ta == 16'h008e)
    |=> !tgt_valid ##0 host_done && host_rsp.rsvd ##1 host_ready)
    else $error("reserved read reached a target");
  post_alias_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && (ta == 16'h0090 || ta == 16'h0095 || ta == 16'h0098 || ta == 16'h009e)
    |=> routed(fixed_io_pkg::TGT_LPC))
    else $error("alias port not forwarded");
  fast_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && ta == 16'h0092 |=> routed(fixed_io_pkg::TGT_RESET))
    else $error("port 92h misrouted");
  pic_sub_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && ta >= 16'h00a0 && ta <= 16'h00bd && ta[1] == 1'b0
    |=> routed(fixed_io_pkg::TGT_PIC_SUB))
    else $error("secondary interrupt port misrouted");
  pwr_port_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    taken_at(16'h00b2, 16'h00b3) |=> routed(fixed_io_pkg::TGT_PWR))
    else $error("power port misrouted");
  game_port_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    taken_at(16'h0200, 16'h020f) |=> routed(fixed_io_pkg::TGT_LPC))
    else $error("game port not forwarded");
  edge_level_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    taken_at(16'h04d0, 16'h04d1) |=> routed(fixed_io_pkg::TGT_PIC_MAIN))
    else $error("edge level port misrouted");
  reset_ctl_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && ta == 16'h0cf9 |=> routed(fixed_io_pkg::TGT_RESET))
    else $error("reset control port misrouted");
  unclaimed_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && (ta == 16'h0081 || ta == 16'h0041 || ta == 16'h0300 || ta == 16'h0cf8)
    |=> host_done && !host_rsp.claim && !tgt_valid)
    else $error("foreign address claimed");
  ack_done_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tgt_valid && tgt_ack |=> host_done && !tgt_valid ##1 host_ready)
    else $error("target answer not returned");

  // ------------------------------------------------------------
  // Holes between the fixed ranges
  // ------------------------------------------------------------
  // Neighbours of the interrupt, timer, port 80h and upper ranges must fall through, so a mask one bit too wide shows up here
  pic_hole_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && (ta == 16'h0022 || ta == 16'h0023 || ta == 16'h003e || ta == 16'h003f)
    |=> host_done && !host_rsp.claim && !tgt_valid)
    else $error("hole beside primary interrupt ports claimed");
  timer_hole_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && (ta == 16'h0041 || ta == 16'h0044 || ta == 16'h0051 || ta == 16'h0054)
    |=> host_done && !host_rsp.claim && !tgt_valid)
    else $error("hole beside timer ports claimed");
  post_hole_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && (ta == 16'h0087 || ta == 16'h0089 || ta == 16'h008a || ta == 16'h008b ||
             ta == 16'h0091 || ta == 16'h0099 || ta == 16'h009a || ta == 16'h009f)
    |=> host_done && !host_rsp.claim && !tgt_valid)
    else $error("hole in port 80h block claimed");
  sub_hole_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && (ta == 16'h00a2 || ta == 16'h00a3 || ta == 16'h00be || ta == 16'h00bf)
    |=> host_done && !host_rsp.claim && !tgt_valid)
    else $error("hole beside secondary interrupt ports claimed");
  upper_hole_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && (ta == 16'h01ff || ta == 16'h0210 || ta == 16'h04cf || ta == 16'h04d2 ||
             ta == 16'h0cfa || ta == 16'h1cf9)
    |=> host_done && !host_rsp.claim && !tgt_valid)
    else $error("hole above the byte ports claimed");

  // ------------------------------------------------------------
  // Handshake and answer
  // ------------------------------------------------------------
  // Done stands one cycle with the host still refused, then the host is free again
  sequence answered;
    host_done && !host_ready && !tgt_valid ##1 host_ready && !host_done;
  endsequence

  // A waiting target sees the same request on every cycle
  sequence held_request;
    tgt_valid && $stable(tgt_sel) && $stable(tgt_cmd);
  endsequence

  post_lpc_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && ta == 16'h0080 && !post_to_pcie |=> routed(fixed_io_pkg::TGT_LPC))
    else $error("port 80h not sent to LPC/eSPI");
  post_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && host_cmd.wr && (ta == 16'h0084 || ta == 16'h0086 || ta == 16'h0088 ||
                            ta == 16'h008c || ta == 16'h008e)
    |=> tgt_valid && tgt_sel == ($past(post_to_pcie) ? fixed_io_pkg::TGT_PCIE
                                                      : fixed_io_pkg::TGT_LPC))
    else $error("write beside port 80h not forwarded");
  alias_pcie_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && post_to_pcie && (ta == 16'h0090 || ta == 16'h0094 || ta == 16'h009c)
    |=> routed(fixed_io_pkg::TGT_LPC))
    else $error("alias port followed the port 80h destination");
  rtc_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take && host_cmd.wr && ta >= 16'h0071 && ta <= 16'h0077
    |=> routed(fixed_io_pkg::TGT_RTC))
    else $error("clock data write split");
  rsvd_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    host_done && host_rsp.rsvd |-> host_rsp.claim &&
    host_rsp.rdata == fixed_io_pkg::FLOAT_DATA)
    else $error("reserved answer malformed");
  cmd_copy_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take |=> tgt_cmd == $past(host_cmd))
    else $error("forwarded command differs from the host cycle");
  issue_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tgt_valid && !tgt_ack |=> held_request)
    else $error("request changed before the target answered");
  slow_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tgt_valid && !tgt_ack |=> !host_done && !host_ready)
    else $error("host freed before the target answered");
  done_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    host_done |-> answered)
    else $error("answer pulse malformed");
  read_data_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tgt_valid && tgt_ack && !tgt_cmd.wr |=> host_done && host_rsp.rdata == $past(tgt_rdata))
    else $error("read data not returned");
  write_float_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tgt_valid && tgt_ack && tgt_cmd.wr |=> host_done && host_rsp.claim &&
    host_rsp.rdata == fixed_io_pkg::FLOAT_DATA)
    else $error("write answer carries data");
  float_miss_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    host_done && !host_rsp.claim |-> host_rsp.rdata == fixed_io_pkg::FLOAT_DATA &&
    !host_rsp.rsvd)
    else $error("unclaimed cycle answered with data");

endmodule : fixed_io_address_decoder

// ### pkg/fixed_io_pkg.sv
// Shared types and constants for the fixed I/O address decoder
package fixed_io_pkg;

  // ------------------------------------------------------------
  // Routing targets
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    TGT_NONE     = 4'h0,
    TGT_RSVD     = 4'h1,
    TGT_PIC_MAIN = 4'h2,
    TGT_PIC_SUB  = 4'h3,
    TGT_TIMER    = 4'h4,
    TGT_NMI      = 4'h5,
    TGT_RTC      = 4'h6,
    TGT_RTC_NMI  = 4'h7,
    TGT_RESET    = 4'h8,
    TGT_PWR      = 4'h9,
    TGT_LPC      = 4'ha,
    TGT_PCIE     = 4'hb
  } target_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_ISSUE = 2'h1,
    ST_RESP  = 2'h3
  } state_e;

  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } io_cmd_s;

  typedef struct packed {
    logic claim;
    logic rsvd;
    logic [7:0] rdata;
  } io_rsp_s;

  // ------------------------------------------------------------
  // Address patterns
  // ------------------------------------------------------------
  localparam logic [15:0] PIC_MASK = 16'hffe2;
  localparam logic [15:0] PIC_MAIN_MATCH = 16'h0020;
  localparam logic [15:0] PIC_SUB_MATCH = 16'h00a0;
  localparam logic [15:0] CFG_IDX_A = 16'h002e;
  localparam logic [15:0] CFG_IDX_B = 16'h004e;
  localparam logic [15:0] TIMER_MASK = 16'hffec;
  localparam logic [15:0] TIMER_MATCH = 16'h0040;
  localparam logic [15:0] BLK8_MASK = 16'hfff8;
  localparam logic [15:0] BLK16_MASK = 16'hfff0;
  localparam logic [15:0] KBC_MATCH = 16'h0060;
  localparam logic [15:0] RTC_MATCH = 16'h0070;
  localparam logic [15:0] POST_PORT = 16'h0080;
  localparam logic [15:0] POST_ALIAS_MATCH = 16'h0090;
  localparam logic [15:0] FAST_RESET = 16'h0092;
  localparam logic [15:0] PWR_BASE = 16'h00b2;
  localparam logic [15:0] GAME_MATCH = 16'h0200;
  localparam logic [15:0] EDGE_LEVEL_BASE = 16'h04d0;
  localparam logic [15:0] RESET_CTL = 16'h0cf9;

  localparam logic [7:0] FLOAT_DATA = 8'hff;

endpackage : fixed_io_pkg
